// ===== fan_pwm_speed_monitor.sv
// Fan PWM generator with start-up boost, sleep and two speed channels.
//
// Behaviour
// - PWM period is fixed near 30 Hz; only the high time varies.
// - Source select 1 takes duty register, 0 takes analog demand.
// - Source select resets to 0, analog demand in control.
// - Open demand input under analog control gives code 2 duty.
// - Source select may change any time; duty source follows at once.
// - Analog demand maps linearly 30 to 100 percent, never below 30.
// - Demand above full scale under analog control sets overheat flag and pulls alarm low.
// - Four-bit readable, writable duty register used under register control.
// - Duty code steps 4.67 percent from 30 up to 100 percent.
// - Full drive after reset and after leaving sleep.
// - Only the sleep bit stops the drive output.
// - Drive keeps pulsing whatever the measured fan speed.
// - Only qualified sense pulses on each input are counted.
// - Per-fan pulses per turn of 1, 2, 4 or 8.
// - Both pulses-per-turn fields reset to two pulses.
// - Each fan has a read-only 9-bit speed register, 25 RPM units.
// - Fine step reads 9 bits; otherwise 8 bits at 50 RPM.
// - Speed above maximum sets that fan's overflow status bit.
// - Overflow clears after a full window below the maximum.
// - Full drive lasts one second, then selected source applies.
// - Overheat flag and alarm release when duty drops below full.
// - Leaving sleep resets registers except configuration.
`timescale 1ns/1ps
`default_nettype none
`include "fan_pwm_defs.svh"

module fan_pwm_speed_monitor #(
  parameter int unsigned START_CYCLES  = `START_CYCLES,
  parameter int unsigned WINDOW_CYCLES = `WINDOW_CYCLES
) (
  input  wire logic                  I_CLOCK,
  input  wire logic                  I_RST_N,
  input  wire fan_pwm_pkg::reg_req_t I_REG_REQ,
  input  wire logic [7:0]            I_ANALOG_DEMAND_CODE,
  input  wire logic                  I_ANALOG_DEMAND_OPEN,
  input  wire logic                  I_ANALOG_DEMAND_OVER,
  input  wire logic                  I_TACH_INPUT_A,
  input  wire logic                  I_TACH_INPUT_B,
  output logic                       O_PWM_DRIVE_PIN,
  output logic                       O_ALARM_N,
  output logic [8:0]                 O_REG_RDATA
);
  import fan_pwm_pkg::*;

  localparam logic [24:0] START_LAST = 25'(START_CYCLES - 1);
  localparam logic [11:0] SLOT_LAST  = 12'(`PWM_SLOT_CYCLES - 1);
  localparam logic [8:0]  IDX_LAST   = 9'(`PWM_SLOTS - 1);

  config_t      cfg_r;
  logic [3:0]   duty_r;
  logic         overheat_r;
  drive_state_t state_r;
  drive_state_t state_nxt;
  logic [24:0]  start_cnt_r;
  logic [11:0]  slot_cnt_r;
  logic [8:0]   slot_idx_r;
  logic [9:0]   dem_s1_r;
  logic [9:0]   dem_s2_r;
  logic [9:0]   dem_s3_r;
  logic [9:0]   dem_r;
  logic [7:0]   dem_code;
  logic         dem_open;
  logic         dem_over;
  logic [15:0]  dem_prod;
  logic [15:0]  dem_quot;
  logic [8:0]   analog_slots;
  logic [8:0]   reg_slots;
  logic [8:0]   on_slots;
  logic         wr_cfg;
  logic         wr_duty;
  logic         sleeping;
  logic         waking;
  speed_t       speed1;
  speed_t       speed2;
  logic [8:0]   rdata_nxt;

  // ========================================================================
  // Register writes
  assign wr_cfg  = I_REG_REQ.wr && I_REG_REQ.addr == `REG_CONFIG;
  assign wr_duty = I_REG_REQ.wr && I_REG_REQ.addr == `REG_DUTY;
  assign sleeping = (state_r == ST_SLEEP);
  assign waking   = sleeping && !cfg_r.sleep_bit;

  // Configuration survives sleep, so it is only touched by reset and writes.
  always_ff @(posedge I_CLOCK or negedge I_RST_N)
    if (!I_RST_N)
      cfg_r <= `CONFIG_RESET;
    else if (wr_cfg)
      cfg_r <= I_REG_REQ.wdata[6:0];

  always_ff @(posedge I_CLOCK or negedge I_RST_N)
    if (!I_RST_N)
      duty_r <= `DUTY_RESET;
    else if (waking)
      duty_r <= `DUTY_RESET;
    else if (wr_duty)
      duty_r <= I_REG_REQ.wdata[3:0];

  // ========================================================================
  // Analog demand front end
  // Each bit updates only when two stages agree, so a word caught mid-change
  // can hold old and new bits for a cycle; the demand moves slowly.
  always_ff @(posedge I_CLOCK or negedge I_RST_N)
    if (!I_RST_N)
    begin
      dem_s1_r <= '0;
      dem_s2_r <= '0;
      dem_s3_r <= '0;
      dem_r <= '0;
    end
    else
    begin
      dem_s1_r <= {I_ANALOG_DEMAND_OVER, I_ANALOG_DEMAND_OPEN,
                   I_ANALOG_DEMAND_CODE};
      dem_s2_r <= dem_s1_r;
      dem_s3_r <= dem_s2_r;
      dem_r <= (dem_s3_r & ~(dem_s2_r ^ dem_s3_r)) |
               (dem_r & (dem_s2_r ^ dem_s3_r));
    end

  assign dem_code = dem_r[7:0];
  assign dem_open = dem_r[8];
  assign dem_over = dem_r[9];

  // ========================================================================
  // Duty selection in slots of one period
  assign dem_prod = {8'h00, dem_code} * `DUTY_SPAN_SLOTS;
  assign dem_quot = dem_prod / `DEMAND_FULL_CODE;
  assign reg_slots = `DUTY_MIN_SLOTS +
                     9'({5'h00, duty_r} * `DUTY_STEP_SLOTS);

  always_comb
  begin
    if (dem_over)
      analog_slots = `DUTY_FULL_SLOTS;
    else if (dem_open)
      analog_slots = `DUTY_MIN_SLOTS +
                     9'({5'h00, `DUTY_OPEN_CODE} * `DUTY_STEP_SLOTS);
    else
      analog_slots = `DUTY_MIN_SLOTS + dem_quot[8:0];
  end

  assign on_slots = cfg_r.pwm_source_select ? reg_slots
                                            : analog_slots;

  // ========================================================================
  // Drive sequencing
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_START:
        if (cfg_r.sleep_bit)
          state_nxt = ST_SLEEP;
        else if (start_cnt_r == START_LAST)
          state_nxt = ST_RUN;
      ST_RUN:
        if (cfg_r.sleep_bit)
          state_nxt = ST_SLEEP;
      ST_SLEEP:
        if (!cfg_r.sleep_bit)
          state_nxt = ST_START;
      default:
        state_nxt = ST_START;
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N)
    if (!I_RST_N)
      state_r <= ST_START;
    else
      state_r <= state_nxt;

  always_ff @(posedge I_CLOCK or negedge I_RST_N)
    if (!I_RST_N)
      start_cnt_r <= '0;
    else if (state_r != ST_START)
      start_cnt_r <= '0;
    else
      start_cnt_r <= start_cnt_r + 25'h0000001;

  // ========================================================================
  // PWM timebase
  // The period never depends on the duty, only the compare point moves.
  always_ff @(posedge I_CLOCK or negedge I_RST_N)
    if (!I_RST_N)
    begin
      slot_cnt_r <= '0;
      slot_idx_r <= '0;
    end
    else if (sleeping)
    begin
      slot_cnt_r <= '0;
      slot_idx_r <= '0;
    end
    else if (slot_cnt_r == SLOT_LAST)
    begin
      slot_cnt_r <= '0;
      slot_idx_r <= (slot_idx_r == IDX_LAST) ? 9'h000
                                             : slot_idx_r + 9'h001;
    end
    else
      slot_cnt_r <= slot_cnt_r + 12'h001;

  // Speed readings never feed this path, so a stalled fan keeps its drive.
  always_ff @(posedge I_CLOCK or negedge I_RST_N)
    if (!I_RST_N)
      O_PWM_DRIVE_PIN <= 1'b0;
    else
      case (state_r)
        ST_START: O_PWM_DRIVE_PIN <= 1'b1;
        ST_RUN:   O_PWM_DRIVE_PIN <= (slot_idx_r < on_slots);
        ST_SLEEP: O_PWM_DRIVE_PIN <= 1'b0;
        default:  O_PWM_DRIVE_PIN <= 1'b0;
      endcase

  // ========================================================================
  // Over-temperature
  always_ff @(posedge I_CLOCK or negedge I_RST_N)
    if (!I_RST_N)
      overheat_r <= 1'b0;
    else if (sleeping)
      overheat_r <= 1'b0;
    else if (dem_over && !cfg_r.pwm_source_select)
      overheat_r <= 1'b1;
    else if (on_slots < `DUTY_FULL_SLOTS)
      overheat_r <= 1'b0;

  assign O_ALARM_N = !overheat_r;

  // ========================================================================
  // Speed channels
  fan_tach_channel #(
    .WINDOW_CYCLES (WINDOW_CYCLES)
  ) u_fan1 (
    .i_clk   (I_CLOCK),
    .i_rst_n (I_RST_N),
    .i_clear (sleeping),
    .i_sense (I_TACH_INPUT_A),
    .i_ppr   (cfg_r.fan1_pulses_per_turn),
    .o_speed (speed1)
  );

  fan_tach_channel #(
    .WINDOW_CYCLES (WINDOW_CYCLES)
  ) u_fan2 (
    .i_clk   (I_CLOCK),
    .i_rst_n (I_RST_N),
    .i_clear (sleeping),
    .i_sense (I_TACH_INPUT_B),
    .i_ppr   (cfg_r.fan2_pulses_per_turn),
    .o_speed (speed2)
  );

  // ========================================================================
  // Register reads
  always_comb
  begin
    rdata_nxt = '0;
    case (I_REG_REQ.addr)
      `REG_CONFIG: rdata_nxt = {2'h0, cfg_r};
      `REG_STATUS:
      begin
        rdata_nxt[`STATUS_F1_OVF]   = speed1.overflow;
        rdata_nxt[`STATUS_F2_OVF]   = speed2.overflow;
        rdata_nxt[`STATUS_OVERHEAT] = overheat_r;
      end
      `REG_DUTY:   rdata_nxt = {5'h00, duty_r};
      `REG_SPEED1: rdata_nxt = cfg_r.fine_step_select ? speed1.value
                             : {1'b0, speed1.value[8:1]};
      `REG_SPEED2: rdata_nxt = cfg_r.fine_step_select ? speed2.value
                             : {1'b0, speed2.value[8:1]};
      default:     rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N)
    if (!I_RST_N)
      O_REG_RDATA <= '0;
    else
      O_REG_RDATA <= rdata_nxt;

  // ========================================================================
  // Checks
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RST_N);

  start_full_a : assert property (
    state_r == ST_START |=> O_PWM_DRIVE_PIN)
    else $error("drive not full during start-up");

  sleep_stop_a : assert property (
    state_r == ST_SLEEP |=> !O_PWM_DRIVE_PIN)
    else $error("drive active while asleep");

  start_len_a : assert property (
    $rose(state_r == ST_RUN) |-> $past(start_cnt_r) == START_LAST)
    else $error("start-up period has wrong length");

  reg_step_a : assert property (
    cfg_r.pwm_source_select |->
      on_slots == 9'h05a + 9'({5'h00, duty_r} * 9'h00e))
    else $error("register duty decode wrong");

  open_dflt_a : assert property (
    !cfg_r.pwm_source_select && dem_open && !dem_over |->
      on_slots == 9'h076)
    else $error("open demand duty wrong");

  duty_floor_a : assert property (
    on_slots >= 9'h05a && on_slots <= 9'h12c)
    else $error("duty outside 30 to 100 percent");

  period_wrap_a : assert property (
    !sleeping && slot_idx_r == IDX_LAST && slot_cnt_r == SLOT_LAST |=>
      slot_idx_r == 9'h000)
    else $error("PWM period does not wrap");

  run_duty_a : assert property (
    state_r == ST_RUN && state_nxt == ST_RUN |=>
      O_PWM_DRIVE_PIN == ($past(slot_idx_r) < $past(on_slots)))
    else $error("drive does not follow selected duty");

  overheat_a : assert property (
    !sleeping && dem_over && !cfg_r.pwm_source_select |=> !O_ALARM_N)
    else $error("overheat not flagged");

  overheat_clr_a : assert property (
    !sleeping && !dem_over && on_slots < 9'h12c |=> !overheat_r)
    else $error("overheat not released");

  cfg_keep_a : assert property (
    sleeping && !wr_cfg |=> $stable(cfg_r))
    else $error("configuration lost in sleep");

  wake_duty_a : assert property (
    waking |=> duty_r == `DUTY_RESET)
    else $error("duty not restored on wake");

  cover_wake_c : cover property (waking ##1 state_r == ST_START);
  cover_reg_c  : cover property (state_r == ST_RUN &&
                                 cfg_r.pwm_source_select);
  cover_hot_c  : cover property (!O_ALARM_N ##1 O_ALARM_N);

endmodule
`default_nettype wire

// ===== fan_pwm_defs.svh
// Offsets, field positions, reset values and timing counts of the fan block.
`ifndef FAN_PWM_DEFS_SVH
`define FAN_PWM_DEFS_SVH

// ==========================================================================
// Timing
`define CLK_HZ           20000000
`define PWM_HZ           30
`define PWM_SLOTS        300
`define PWM_SLOT_CYCLES  (`CLK_HZ / (`PWM_HZ * `PWM_SLOTS))
`define START_TIME_MS    1000
`define START_CYCLES     ((`CLK_HZ / 1000) * `START_TIME_MS)
`define WINDOW_TIME_MS   2400
`define WINDOW_CYCLES    ((`CLK_HZ / 1000) * `WINDOW_TIME_MS)

// ==========================================================================
// Duty mapping in slots of one period
`define DUTY_MIN_SLOTS   9'h05a
`define DUTY_STEP_SLOTS  9'h00e
`define DUTY_SPAN_SLOTS  16'h00d2
`define DUTY_FULL_SLOTS  9'h12c
`define DEMAND_FULL_CODE 16'h00ff
`define DUTY_OPEN_CODE   4'h2
`define DUTY_RESET       4'h2

// ==========================================================================
// Register offsets
`define REG_CONFIG       3'h0
`define REG_STATUS       3'h1
`define REG_DUTY         3'h2
`define REG_SPEED1       3'h3
`define REG_SPEED2       3'h4

// ==========================================================================
// Configuration and status fields
`define CONFIG_RESET     7'h0a
`define STATUS_F1_OVF    3
`define STATUS_F2_OVF    4
`define STATUS_OVERHEAT  5
`define SPEED_MAX        9'h1ff

`endif

// ===== fan_pwm_pkg.sv
// Types shared by the fan controller modules.
package fan_pwm_pkg;

  // ========================================================================
  // Configuration register, bits 6 down to 0
  typedef struct packed {
    logic       fine_step_select;
    logic       pwm_source_select;
    logic [1:0] fan2_pulses_per_turn;
    logic [1:0] fan1_pulses_per_turn;
    logic       sleep_bit;
  } config_t;

  // ========================================================================
  // Register access from the serial interface front end
  typedef struct packed {
    logic       wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       overflow;
    logic [8:0] value;
  } speed_t;

  typedef enum logic [1:0] {
    ST_START,
    ST_RUN,
    ST_SLEEP
  } drive_state_t;

endpackage

// ===== fan_tach_channel.sv
// One fan speed measurement channel.
`timescale 1ns/1ps
`default_nettype none
`include "fan_pwm_defs.svh"

module fan_tach_channel #(
  parameter int unsigned WINDOW_CYCLES = `WINDOW_CYCLES
) (
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  input  wire logic                i_clear,
  input  wire logic                i_sense,
  input  wire logic [1:0]          i_ppr,
  output var  fan_pwm_pkg::speed_t o_speed
);
  import fan_pwm_pkg::*;

  localparam logic [25:0] WIN_LAST = 26'(WINDOW_CYCLES - 1);

  logic        s1_r;
  logic        s2_r;
  logic        s3_r;
  logic        level_r;
  logic        level_d_r;
  logic [25:0] win_r;
  logic [12:0] cnt_r;
  logic [12:0] turns;
  logic        win_end;

  // ========================================================================
  // Qualified sense pulses
  // The comparator output only rises on pulses above the sense threshold.
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_r <= 1'b0;
      level_d_r <= 1'b0;
    end
    else
    begin
      s1_r <= i_sense;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        level_r <= s3_r;
      level_d_r <= level_r;
    end

  // ========================================================================
  // Measurement window
  // A window of this length makes one pulse per turn worth one speed unit.
  assign win_end = (win_r == WIN_LAST);

  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
      win_r <= '0;
    else if (i_clear || win_end)
      win_r <= '0;
    else
      win_r <= win_r + 26'h0000001;

  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
      cnt_r <= '0;
    else if (i_clear || win_end)
      cnt_r <= '0;
    else if (level_r && !level_d_r && cnt_r != 13'h1fff)
      cnt_r <= cnt_r + 13'h0001;

  assign turns = cnt_r >> i_ppr;

  // A full window under the maximum clears the overflow flag by itself.
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
      o_speed <= '0;
    else if (i_clear)
      o_speed <= '0;
    else if (win_end)
    begin
      o_speed.overflow <= (turns > 13'(`SPEED_MAX));
      o_speed.value <= (turns > 13'(`SPEED_MAX)) ? `SPEED_MAX
                                                 : turns[8:0];
    end

  // ========================================================================
  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  ovf_sets_a : assert property (
    win_end && !i_clear && turns > 13'(`SPEED_MAX) |=>
      o_speed.overflow && o_speed.value == `SPEED_MAX)
    else $error("overflow not flagged at window end");

  ovf_clears_a : assert property (
    win_end && !i_clear && turns <= 13'(`SPEED_MAX) |=> !o_speed.overflow)
    else $error("overflow not cleared after a low window");

  speed_hold_a : assert property (
    !win_end && !i_clear |=> $stable(o_speed))
    else $error("speed changed outside window end");

  cover_ovf_c : cover property (win_end && turns > 13'(`SPEED_MAX));

endmodule
`default_nettype wire

// ===== fan_drive_model.sv
// Behavioural fan, drive transistor and current-sense comparator pair.
`timescale 1ns/1ps
`default_nettype none

module fan_drive_model #(
  parameter int unsigned HALF = 3
) (
  input  wire logic        i_clk,
  input  wire logic        i_drive,
  input  wire logic        i_start,
  input  wire logic [15:0] i_count_a,
  input  wire logic [15:0] i_count_b,
  output logic             o_tach_a,
  output logic             o_tach_b
);
  // ==========================================================================
  // Pulse sources
  // A rotor only commutates while the transistor conducts, so the pulse
  // trains pause whenever the drive pin is low; a slow fan is a larger HALF.
  int left_a;
  int left_b;
  int tick;

  initial
  begin
    o_tach_a = 1'b0;
    o_tach_b = 1'b0;
    left_a = 0;
    left_b = 0;
    tick = 0;
  end

  // Comparator output is high only while a pulse is above threshold.
  always @(posedge i_clk)
  begin
    if (i_start)
    begin
      left_a = 2 * i_count_a;
      left_b = 2 * i_count_b;
      tick = 0;
    end
    else if (i_drive && (left_a > 0 || left_b > 0))
    begin
      tick = tick + 1;
      if (tick >= HALF)
      begin
        tick = 0;
        if (left_a > 0)
        begin
          o_tach_a <= ~o_tach_a;
          left_a = left_a - 1;
        end
        if (left_b > 0)
        begin
          o_tach_b <= ~o_tach_b;
          left_b = left_b - 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== test_fan_pwm_speed_monitor.sv
// Self-checking testbench of the fan PWM and speed monitor.
`timescale 1ns/1ps
`default_nettype none

module test_fan_pwm_speed_monitor;
  import fan_pwm_pkg::*;
  // Short start and window counts keep the run small.
  localparam int START = 50;
  localparam int WIN   = 4000;

  logic       clk;
  logic       rst_n;
  reg_req_t   req;
  logic [7:0] dem_code;
  logic       dem_open;
  logic       dem_over;
  logic       tach_a;
  logic       tach_b;
  logic       drive;
  logic       alarm_n;
  logic [8:0] rdata;
  logic       fan_start;
  logic [15:0] cnt_a;
  logic [15:0] cnt_b;
  int         failures;
  int         checks;
  int         cyc;

  fan_pwm_speed_monitor #(
    .START_CYCLES (START),
    .WINDOW_CYCLES(WIN)
  ) i_fan_pwm_speed_monitor (
    .I_CLOCK             (clk),
    .I_RST_N             (rst_n),
    .I_REG_REQ           (req),
    .I_ANALOG_DEMAND_CODE(dem_code),
    .I_ANALOG_DEMAND_OPEN(dem_open),
    .I_ANALOG_DEMAND_OVER(dem_over),
    .I_TACH_INPUT_A      (tach_a),
    .I_TACH_INPUT_B      (tach_b),
    .O_PWM_DRIVE_PIN     (drive),
    .O_ALARM_N           (alarm_n),
    .O_REG_RDATA         (rdata)
  );

  fan_drive_model i_fan_drive_model (
    .i_clk    (clk),
    .i_drive  (drive),
    .i_start  (fan_start),
    .i_count_a(cnt_a),
    .i_count_b(cnt_b),
    .o_tach_a (tach_a),
    .o_tach_b (tach_b)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) cyc <= rst_n ? cyc + 1 : 0;

  // ==========================================================================
  // Shared tasks
  task automatic complete_run();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // The idle cycle after the strobe keeps a following call off this edge.
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    req = '{wr: 1'b1, addr: a, wdata: d};
    @(negedge clk);
    req.wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic reg_rd(input logic [2:0] a, output logic [8:0] q);
    req.addr = a;
    @(negedge clk);
    q = rdata;
  endtask

  task automatic wait_cyc(input int t);
    for (int n = 0; n < 100000 && cyc < t; n++) @(negedge clk);
    if (cyc < t)
    begin
      failures++;
      complete_run();
    end
  endtask

  task automatic wait_pin(input bit on_drive, input logic v);
    for (int n = 0; n < 8 && (on_drive ? drive : alarm_n) !== v; n++)
      @(negedge clk);
    if ((on_drive ? drive : alarm_n) !== v)
    begin
      failures++;
      complete_run();
    end
  endtask

  task automatic pulses(input int a, input int b);
    cnt_a = 16'(a);
    cnt_b = 16'(b);
    fan_start = 1'b1;
    @(negedge clk);
    fan_start = 1'b0;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    logic       held;
    logic [8:0] q;
    held = 1'b1;
    check({7'h0, drive, alarm_n}, 9'h001);
    check(rdata, 9'h000);
    rst_n = 1'b1;
    @(negedge clk);
    repeat (START - 4)
    begin
      @(negedge clk);
      held = held & drive;
    end
    check({8'h0, held}, 9'h001);
    reg_rd(3'h0, q);
    check(q, 9'h00a);
    reg_rd(3'h2, q);
    check(q, 9'h002);
    reg_rd(3'h5, q);
    check(q, 9'h000);
  endtask

  task automatic t_regs();
    logic [8:0] q;
    reg_wr(3'h2, 8'h17);
    reg_rd(3'h2, q);
    check(q, 9'h007);
    reg_wr(3'h3, 8'hff);
    reg_rd(3'h3, q);
    check(q, 9'h000);
  endtask

  task automatic t_overheat();
    logic [8:0] q;
    dem_over = 1'b1;
    wait_pin(1'b0, 1'b0);
    check({8'h0, alarm_n}, 9'h000);
    reg_rd(3'h1, q);
    check(q, 9'h020);
    dem_over = 1'b0;
    wait_pin(1'b0, 1'b1);
    reg_rd(3'h1, q);
    check({q[7:0], alarm_n}, 9'h001);
    // An open demand pin selects the code 2 duty, never an overheat.
    dem_open = 1'b1;
    repeat (8) @(negedge clk);
    reg_rd(3'h1, q);
    check({q[7:0], alarm_n}, 9'h001);
    dem_open = 1'b0;
    repeat (8) @(negedge clk);
  endtask

  // Full duty keeps the fan model pulsing through both windows.
  task automatic t_tach();
    logic [8:0] q;
    reg_wr(3'h0, 8'h78);
    reg_wr(3'h2, 8'h0f);
    wait_cyc(2 * WIN + 100);
    pulses(600, 80);
    wait_cyc(3 * WIN + 100);
    reg_rd(3'h3, q);
    check(q, 9'h1ff);
    reg_rd(3'h4, q);
    check(q, 9'h00a);
    reg_rd(3'h1, q);
    check(q, 9'h008);
    reg_wr(3'h0, 8'h32);
    wait_cyc(3 * WIN + 200);
    pulses(40, 44);
    wait_cyc(4 * WIN + 100);
    reg_rd(3'h3, q);
    check(q, 9'h00a);
    reg_rd(3'h4, q);
    check(q, 9'h005);
    reg_rd(3'h1, q);
    check(q, 9'h000);
  endtask

  task automatic t_sleep();
    logic [8:0] q;
    reg_wr(3'h0, 8'h33);
    wait_pin(1'b1, 1'b0);
    check({8'h0, drive}, 9'h000);
    reg_wr(3'h2, 8'h05);
    reg_rd(3'h3, q);
    check(q, 9'h000);
    reg_wr(3'h0, 8'h32);
    wait_pin(1'b1, 1'b1);
    check({8'h0, drive}, 9'h001);
    reg_rd(3'h2, q);
    check(q, 9'h002);
    reg_rd(3'h0, q);
    check(q, 9'h032);
  endtask

  initial
  begin
    rst_n = 1'b0;
    req = '0;
    dem_code = 8'h80;
    dem_open = 1'b0;
    dem_over = 1'b0;
    fan_start = 1'b0;
    cnt_a = 16'h0000;
    cnt_b = 16'h0000;
    failures = 0;
    checks = 0;
    repeat (20) @(negedge clk);
    t_reset();
    t_regs();
    t_overheat();
    t_tach();
    t_sleep();
    complete_run();
  end
endmodule
`default_nettype wire
